// File: core/dboh_pkg.sv
// dboh_pkg: shared constants and types for the bus ownership handshake.
// assumes a single clock domain; no software-visible register map of its own.
package dboh_pkg;
  // number of dma channels served by the shared bus
  localparam int unsigned DBOH_CHANNELS    = 4;
  // reset value of the hold-acknowledge enable bit: processor owns the bus
  localparam logic        DBOH_HOLD_ACKNOWLEDGE_EN_RST = 1'b0;
  // bit positions inside the bus request status/control byte
  localparam int unsigned DBOH_BIT_HOLD_ACKNOWLEDGE_EN = 0;
  localparam int unsigned DBOH_BIT_AEN     = 1;
  localparam int unsigned DBOH_REQ_W       = 8;

  // ownership states of the dma side
  typedef enum logic [1:0] {
    DBOH_IDLE,
    DBOH_WAIT_ACK,
    DBOH_OWN,
    DBOH_RELEASE
  } dboh_state_t;
endpackage : dboh_pkg

// File: core/dboh_arbiter.sv
// dboh_arbiter: ownership handshake between processor and dma engine on one shared bus.
// assumes dma engine logic on the same clock; processor writes/reads the bus request byte.
`timescale 1ns/1ps
module dboh_arbiter
  import dboh_pkg::*;
#(
  parameter int unsigned CHANNELS = dboh_pkg::DBOH_CHANNELS
) (
  // clock, reset, enable
  input  wire logic                               mclk,
  input  wire logic                               reset,
  input  wire logic                               clk_en,
  // processor side: bus request byte
  input  wire logic                               req_wr,
  input  wire logic [dboh_pkg::DBOH_REQ_W-1:0]    req_wdata,
  output logic      [dboh_pkg::DBOH_REQ_W-1:0]    req_rdata,
  // dma engine side
  input  wire logic [CHANNELS-1:0]                chan_request,
  input  wire logic                               transfer_last,
  input  wire logic                               single_mode,
  output logic                                    hold_request,
  output logic                                    hold_acknowledge,
  output logic                                    address_enable,
  output logic                                    dma_drive_bus,
  output logic [CHANNELS-1:0]                     chan_suspend
);
  import dboh_pkg::*;

  // refuse channel counts that the suspend vector is not sized for
  if (CHANNELS < 1 || CHANNELS > 32) begin : g_bad_channels
    $error("dboh_arbiter: CHANNELS out of range");
  end

  dboh_state_t state;
  dboh_state_t next_state;
  logic        hold_ack_enable_bit;
  logic        next_hold_ack_enable_bit;
  logic        any_req;
  logic        transfer_done;

  // decoded request; a transfer ends on its last cycle or, in single mode, each byte
  assign any_req       = |chan_request;
  assign transfer_done = transfer_last || single_mode;

  // software-written enable bit
  always_comb begin
    next_hold_ack_enable_bit = hold_ack_enable_bit;
    if (req_wr) begin
      next_hold_ack_enable_bit = req_wdata[DBOH_BIT_HOLD_ACKNOWLEDGE_EN];
    end
  end

  // ownership state machine
  always_comb begin
    next_state = state;
    case (state)
      DBOH_IDLE: begin
        if (any_req) begin
          next_state = DBOH_WAIT_ACK;
        end
      end
      DBOH_WAIT_ACK: begin
        if (hold_acknowledge) begin
          next_state = DBOH_OWN;
        end else if (!any_req) begin
          next_state = DBOH_IDLE;
        end
      end
      DBOH_OWN: begin
        // leave only at a boundary: request gone or ack withdrawn
        if (transfer_done && (!any_req || !hold_ack_enable_bit)) begin
          next_state = DBOH_RELEASE;
        end
      end
      DBOH_RELEASE: begin
        next_state = DBOH_IDLE;
      end
      default: begin
        next_state = DBOH_IDLE;
      end
    endcase
  end

  // ownership state register; clk_en freezes it, reset wins regardless
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= DBOH_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // enable bit register; a write with clk_en low is simply lost
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_ack_enable_bit <= DBOH_HOLD_ACKNOWLEDGE_EN_RST;
    end else if (clk_en) begin
      hold_ack_enable_bit <= next_hold_ack_enable_bit;
    end
  end

  // the gate is combinational so hold acknowledge follows hold request with no added delay; address enable comes a cycle later
  assign hold_request     = (state == DBOH_WAIT_ACK) || (state == DBOH_OWN);
  assign hold_acknowledge = hold_request && hold_ack_enable_bit;
  assign address_enable   = (state == DBOH_OWN);
  assign dma_drive_bus    = address_enable;
  // channels run only while dma owns the bus
  assign chan_suspend     = {CHANNELS{!address_enable}};

  // status readback: live address enable plus enable bit
  always_comb begin
    req_rdata                   = '0;
    req_rdata[DBOH_BIT_HOLD_ACKNOWLEDGE_EN] = hold_ack_enable_bit;
    req_rdata[DBOH_BIT_AEN]     = address_enable;
  end

  // checks pause while clk_en is low, since no state moves then
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !clk_en);

  // request, acknowledge and take-over order
  property p_first_request;
    (state == DBOH_IDLE) && any_req |=> hold_request;
  endproperty
  a_first_request: assert property (p_first_request)
    else $error("hold request not raised for a channel request");

  property p_no_drive_without_ack;
    (state == DBOH_WAIT_ACK) && !hold_acknowledge |=> !address_enable;
  endproperty
  a_no_drive_without_ack: assert property (p_no_drive_without_ack)
    else $error("address enable rose without hold acknowledge");

  property p_ack_gives_bus;
    (state == DBOH_WAIT_ACK) && hold_acknowledge |=> address_enable;
  endproperty
  a_ack_gives_bus: assert property (p_ack_gives_bus)
    else $error("bus not taken after acknowledge");

  // release only at a boundary, and then completely
  property p_release_drops_both;
    address_enable && transfer_done && !any_req |=> !address_enable && !hold_request;
  endproperty
  a_release_drops_both: assert property (p_release_drops_both)
    else $error("release kept address enable or hold request");

  property p_gate;
    hold_request && hold_ack_enable_bit |-> hold_acknowledge;
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate did not acknowledge with enable set");

  property p_no_ack_when_disabled;
    hold_request && !hold_ack_enable_bit |-> !hold_acknowledge;
  endproperty
  a_no_ack_when_disabled: assert property (p_no_ack_when_disabled)
    else $error("acknowledge given with enable bit cleared");

  property p_no_mid_release;
    address_enable && !transfer_done |=> address_enable;
  endproperty
  a_no_mid_release: assert property (p_no_mid_release)
    else $error("bus released mid transfer");

  property p_release_when_disabled;
    address_enable && !hold_ack_enable_bit && transfer_done |=> !address_enable;
  endproperty
  a_release_when_disabled: assert property (p_release_when_disabled)
    else $error("bus kept after enable cleared at boundary");

  // status and channel suspension follow address enable
  property p_status_live;
    req_rdata[DBOH_BIT_AEN] == address_enable;
  endproperty
  a_status_live: assert property (p_status_live)
    else $error("status bit differs from address enable");

  property p_suspend;
    !address_enable |-> &chan_suspend;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("channel running while processor owns bus");

  property p_run;
    address_enable |-> chan_suspend == '0;
  endproperty
  a_run: assert property (p_run)
    else $error("channel suspended while dma owns bus");

  property p_single_drop;
    address_enable && single_mode && !hold_ack_enable_bit |=> !address_enable ##1 !hold_request;
  endproperty
  a_single_drop: assert property (p_single_drop)
    else $error("single mode did not drop hold request");

  // reset and processor writes of the enable bit
  property p_reset_clears;
    disable iff (1'b0)
    reset |=> (state == DBOH_IDLE) && !hold_ack_enable_bit;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset left the bus granted to dma");

  property p_write_takes;
    req_wr |=> hold_ack_enable_bit == $past(req_wdata[DBOH_BIT_HOLD_ACKNOWLEDGE_EN]);
  endproperty
  a_write_takes: assert property (p_write_takes)
    else $error("enable bit did not follow the processor write");

  // main scenarios: grant, acquire, single byte, freeze, reset
  c_grant: cover property (hold_acknowledge ##1 address_enable);
  c_acquire: cover property (address_enable && !hold_ack_enable_bit ##[1:20] !address_enable);
  c_single: cover property (address_enable && single_mode ##1 !address_enable);
  c_freeze: cover property (disable iff (reset) !clk_en && req_wr);
  c_mid_reset: cover property (disable iff (1'b0) hold_request && reset);
endmodule : dboh_arbiter

// File: verification/dboh_dma_model.sv
// dboh_dma_model: behavioural dma engine facing the arbiter.
// assumes inputs change just after the rising edge of mclk.
`timescale 1ns/1ps
module dboh_dma_model (
  // clock
  input  wire logic       mclk,
  // control from the bench
  input  wire logic       want,
  input  wire logic [3:0] len,
  // arbiter side
  input  wire logic       address_enable,
  output logic      [3:0] chan_request,
  output logic            transfer_last
);
  logic [3:0] cnt = 4'h0;
  // one channel asks while wanted; the burst is never cut short by the model
  assign chan_request  = {3'h0, want};
  // owned cycles are counted only while address enable marks them as dma cycles
  assign transfer_last = address_enable && (cnt == len - 4'h1);
  always @(posedge mclk) begin
    cnt <= (address_enable && cnt != len - 4'h1) ? cnt + 4'h1 : 4'h0;
  end
endmodule : dboh_dma_model

// File: verification/tb.sv
// tb: self-checking bench for the bus ownership arbiter.
// assumes the dma model above and the arbiter's own assertions.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module tb;
  import dboh_pkg::*;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       req_wr = 1'b0;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] req_rdata;
  logic [3:0] chan_request, chan_suspend;
  logic       transfer_last, single_mode = 1'b0, want = 1'b0;
  logic       clk_en = 1'b1;
  logic       hold_request, hold_acknowledge, address_enable, dma_drive_bus;
  int         mismatches = 0;
  int         checked = 0;
  always #4 mclk = ~mclk;
  dboh_arbiter dut (.mclk(mclk), .reset(reset), .clk_en(clk_en), .req_wr(req_wr),
    .req_wdata(req_wdata), .req_rdata(req_rdata), .chan_request(chan_request),
    .transfer_last(transfer_last), .single_mode(single_mode),
    .hold_request(hold_request), .hold_acknowledge(hold_acknowledge),
    .address_enable(address_enable), .dma_drive_bus(dma_drive_bus),
    .chan_suspend(chan_suspend));
  dboh_dma_model dma (.mclk(mclk), .want(want), .len(4'h4),
    .address_enable(address_enable), .chan_request(chan_request),
    .transfer_last(transfer_last));
  task automatic step();
    @(posedge mclk) #1;
  endtask : step
  // processor write of the enable bit, one-cycle strobe
  task automatic wr(input logic v);
    req_wr = 1'b1;
    req_wdata = {7'h00, v};
    step();
    req_wr = 1'b0;
  endtask : wr
  // bounded wait on the dma ownership status, as firmware polls it
  task automatic wait_own(input logic v);
    for (int i = 0; i < 20 && req_rdata[1] !== v; i++) step();
    `CHK(req_rdata[1], v)
  endtask : wait_own
  task automatic t_reset();
    `CHK(req_rdata, 8'h00)
    `CHK(chan_suspend, 4'hF)
  endtask : t_reset
  task automatic t_grant();
    want = 1'b1;
    step();
    step();
    `CHK(address_enable, 1'b0)
    wr(1'b1);
    `CHK(hold_acknowledge, 1'b1)
    `CHK(req_rdata[0], 1'b1)
    wait_own(1'b1);
    `CHK({dma_drive_bus, address_enable}, 2'h3)
    `CHK(chan_suspend, 4'h0)
  endtask : t_grant
  // clear the enable mid-burst, take the bus back at the boundary, then hand it back again
  task automatic t_acquire();
    wr(1'b0);
    `CHK(address_enable, 1'b1)
    wait_own(1'b0);
    `CHK({hold_request, chan_suspend}, 5'h0F)
    repeat (3) step();
    `CHK({hold_request, hold_acknowledge, address_enable}, 3'h4)
    wr(1'b1);
    `CHK(hold_acknowledge, 1'b1)
    wait_own(1'b1);
  endtask : t_acquire
  // single-byte mode drops ownership at the first boundary after withdrawal
  task automatic t_single();
    single_mode = 1'b1;
    wr(1'b0);
    `CHK(address_enable, 1'b1)
    step();
    `CHK({address_enable, hold_request}, 2'h0)
    want = 1'b0;
    single_mode = 1'b0;
  endtask : t_single
  // frozen clock enable loses a write; a mid-run reset wins over a write
  task automatic t_freeze();
    step();
    clk_en = 1'b0;
    want = 1'b1;
    wr(1'b1);
    `CHK(req_rdata, 8'h00)
    `CHK(hold_request, 1'b0)
    clk_en = 1'b1;
    step();
    `CHK({hold_request, hold_acknowledge}, 2'h2)
    reset = 1'b1;
    wr(1'b1);
    reset = 1'b0;
    `CHK({req_rdata, hold_request}, 9'h000)
    `CHK(chan_suspend, 4'hF)
    step();
    `CHK({hold_request, hold_acknowledge}, 2'h2)
  endtask : t_freeze
  // requests vanish mid-burst: the bus goes back at the next boundary
  task automatic t_done();
    wr(1'b1);
    wait_own(1'b1);
    want = 1'b0;
    step();
    `CHK(address_enable, 1'b1)
    wait_own(1'b0);
    `CHK({hold_request, req_rdata}, 9'h001)
  endtask : t_done
  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // cut a hang short at 2500 cycles, well beyond the few dozen cycles needed
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset = 1'b0;
    t_reset();
    t_grant();
    t_acquire();
    t_single();
    t_freeze();
    t_done();
    report_and_stop();
  end
endmodule : tb
